// ==== include/bst_pkg.sv ====
// Constants for the boundary-scan instruction unit
package bst_pkg;
  localparam int IR_WIDTH = 10;
  localparam int USER_SIG_WIDTH = 32;
  localparam int ID_WIDTH = 32;
  localparam logic [9:0] OP_SAMPLE = 10'h005;
  localparam logic [9:0] OP_EXTEST = 10'h00F;
  localparam logic [9:0] OP_BYPASS = 10'h3FF;
  localparam logic [9:0] OP_USERSIG = 10'h007;
  localparam logic [9:0] OP_IDENT = 10'h006;
  localparam logic [9:0] OP_FLOAT = 10'h00B;
  localparam logic [9:0] OP_CLAMP = 10'h00A;
  localparam logic [9:0] OP_USER_A = 10'h00C;
  localparam logic [9:0] OP_USER_B = 10'h00E;
  localparam logic [9:0] IR_CAPTURE_VAL = 10'h001;
  localparam logic [9:0] IR_RESET_VAL = OP_IDENT;
  localparam logic [31:0] USER_SIG_DEFAULT = 32'hFFFFFFFF;
  // Arbitrary neutral identity values
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [15:0] ID_PART = 16'h1234;
  localparam logic [10:0] ID_MAKER = 11'h055;
  localparam int BSR_SMALL = 240;
  localparam int BSR_MID = 480;
  localparam int BSR_LARGE_A = 636;
  localparam int BSR_LARGE_B = 816;
  typedef enum logic [3:0] {
    TL_RESET, RUN_IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bst_tap_t;
  typedef enum logic [2:0] {
    PATH_BYPASS, PATH_IDENT, PATH_USERSIG, PATH_BSR, PATH_USER_A, PATH_USER_B
  } bst_path_t;
endpackage

// ==== rtl/bst_skid.sv ====
// Two-entry valid/ready buffer for the shifted-out data bit
module bst_skid import bst_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clkEn, // Clock enable
  input wire logic inValid, // Producer has a bit
  output logic inReady, // Buffer can take a bit
  input wire logic inData, // Bit in
  output logic outValid, // Buffer holds a bit
  input wire logic outReady, // Consumer takes a bit
  output logic outData // Oldest bit
);
  logic [1:0] mem_q;
  logic [1:0] count_q;
  logic rdPtr_q;
  logic wrPtr_q;
  logic push;
  logic pop;

  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q <= 2'h0;
      wrPtr_q <= 1'b0;
    end else if (clkEn && push) begin
      mem_q[wrPtr_q] <= inData;
      wrPtr_q <= ~wrPtr_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else if (clkEn) begin
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== rtl/bst_tap_unit.sv ====
// Boundary-scan test access port with instruction decode
// Functional notes
// - Instruction register ten bits, shifted serially
// - Sample/preload captures pins, preloads pattern
// - Extest drives register, captures input pins
// - Bypass puts one-bit register in path
// - User signature register, 32 bits, shifted out
// - Unset user signature reads all ones
// - Identification opcode shifts identity value out
// - Float instruction: bypass path, pins tri-stated
// - Clamp: bypass path, pins hold register
// - Two user opcodes route external chains
// - Test modes leave pull-ups, bus-hold alone
// - Port active with core supply alone
// - Boundary register length set per variant
// - Programming instructions share this port
// - Identity: version, part, maker, LSB one
// - User chains expose controller state, signals
module bst_tap_unit import bst_pkg::*; #(
  parameter int BSR_LEN = BSR_SMALL,
  parameter logic [31:0] USER_SIG_VALUE = USER_SIG_DEFAULT
) (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic clkEn, // Freezes all state when low
  input wire logic testClk, // Test clock pin
  input wire logic modeSel, // Test mode select pin
  input wire logic testDataIn, // Test data input pin
  output logic testDataOut, // Test data output pin
  output logic testDataOutEn, // Output enable for test data out
  input wire logic [BSR_LEN-1:0] pinIn, // Levels seen at device pins
  input wire logic [BSR_LEN-1:0] coreOut, // Core logic output levels
  input wire logic [BSR_LEN-1:0] coreOutEn, // Core logic output enables
  input wire logic pullKeepIn, // Configured pull-up and bus-hold
  output logic [BSR_LEN-1:0] pinOut, // Levels driven to pins
  output logic [BSR_LEN-1:0] pinOutEn, // Pin drive enables
  output logic pullKeepOut, // Pull-up and bus-hold enable
  output logic [9:0] activeInstr, // Current instruction
  output logic userSelA, // First user chain selected
  output logic userSelB, // Second user chain selected
  output logic [3:0] userTapState, // Controller state for user logic
  output logic userTdi, // Test data in for user logic
  output logic userCapture, // Capture-DR pulse for user chain
  output logic userShift, // Shift-DR pulse for user chain
  output logic userUpdate, // Update-DR pulse for user chain
  input wire logic userTdo, // Serial return from user chain
  input wire logic downReady // Sink of test data out is ready
);
  logic [1:0] tckSync_q;
  logic [1:0] tmsSync_q;
  logic [1:0] tdiSync_q;
  logic [1:0] utdoSync_q;
  logic [BSR_LEN-1:0] pinMeta_q;
  logic [BSR_LEN-1:0] pinSync_q;
  logic tckPrev_q;
  logic tckRise;
  logic tckFall;
  bst_tap_t state_q;
  bst_tap_t state_d;
  logic [IR_WIDTH-1:0] irShift_q;
  logic [IR_WIDTH-1:0] ir_q;
  logic bypass_q;
  logic [ID_WIDTH-1:0] idShift_q;
  logic [USER_SIG_WIDTH-1:0] sigShift_q;
  logic [BSR_LEN-1:0] bsrShift_q;
  logic [BSR_LEN-1:0] bsrHold_q;
  bst_path_t path;
  logic serialBit;
  logic bufValid;
  logic bufData;
  logic bufInReady;
  logic tdoDrive;
  logic [ID_WIDTH-1:0] identity;
  logic [BSR_LEN-1:0] capVal;

  assign identity = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign tckRise = tckSync_q[1] && !tckPrev_q;
  assign tckFall = !tckSync_q[1] && tckPrev_q;

  // Pin inputs pass two flops; port stays live on core power alone
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tckSync_q <= 2'h0;
      tmsSync_q <= 2'h3;
      tdiSync_q <= 2'h3;
      utdoSync_q <= 2'h0;
      pinMeta_q <= '0;
      pinSync_q <= '0;
      tckPrev_q <= 1'b0;
    end else if (clkEn) begin
      tckSync_q <= {tckSync_q[0], testClk};
      tmsSync_q <= {tmsSync_q[0], modeSel};
      tdiSync_q <= {tdiSync_q[0], testDataIn};
      utdoSync_q <= {utdoSync_q[0], userTdo};
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
      tckPrev_q <= tckSync_q[1];
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      TL_RESET: state_d = tmsSync_q[1] ? TL_RESET : RUN_IDLE;
      RUN_IDLE: state_d = tmsSync_q[1] ? SEL_DR : RUN_IDLE;
      SEL_DR: state_d = tmsSync_q[1] ? SEL_IR : CAP_DR;
      CAP_DR: state_d = tmsSync_q[1] ? EX1_DR : SH_DR;
      SH_DR: state_d = tmsSync_q[1] ? EX1_DR : SH_DR;
      EX1_DR: state_d = tmsSync_q[1] ? UPD_DR : PA_DR;
      PA_DR: state_d = tmsSync_q[1] ? EX2_DR : PA_DR;
      EX2_DR: state_d = tmsSync_q[1] ? UPD_DR : SH_DR;
      UPD_DR: state_d = tmsSync_q[1] ? SEL_DR : RUN_IDLE;
      SEL_IR: state_d = tmsSync_q[1] ? TL_RESET : CAP_IR;
      CAP_IR: state_d = tmsSync_q[1] ? EX1_IR : SH_IR;
      SH_IR: state_d = tmsSync_q[1] ? EX1_IR : SH_IR;
      EX1_IR: state_d = tmsSync_q[1] ? UPD_IR : PA_IR;
      PA_IR: state_d = tmsSync_q[1] ? EX2_IR : PA_IR;
      EX2_IR: state_d = tmsSync_q[1] ? UPD_IR : SH_IR;
      UPD_IR: state_d = tmsSync_q[1] ? SEL_DR : RUN_IDLE;
      default: state_d = TL_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= TL_RESET;
    end else if (clkEn && tckRise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift and update
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irShift_q <= IR_CAPTURE_VAL;
      ir_q <= IR_RESET_VAL;
    end else if (clkEn && tckRise) begin
      if (state_q == TL_RESET) begin
        ir_q <= IR_RESET_VAL;
      end else if (state_q == CAP_IR) begin
        irShift_q <= IR_CAPTURE_VAL;
      end else if (state_q == SH_IR) begin
        irShift_q <= {tdiSync_q[1], irShift_q[IR_WIDTH-1:1]};
      end else if (state_q == UPD_IR) begin
        ir_q <= irShift_q;
      end
    end
  end

  always_comb begin
    case (ir_q)
      OP_IDENT: path = PATH_IDENT;
      OP_USERSIG: path = PATH_USERSIG;
      OP_SAMPLE: path = PATH_BSR;
      OP_EXTEST: path = PATH_BSR;
      OP_USER_A: path = PATH_USER_A;
      OP_USER_B: path = PATH_USER_B;
      OP_FLOAT: path = PATH_BYPASS;
      OP_CLAMP: path = PATH_BYPASS;
      default: path = PATH_BYPASS;
    endcase
  end

  // Extest captures pins; sample also captures pins in normal mode
  assign capVal = pinSync_q;

  // Data registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_q <= 1'b0;
      idShift_q <= '0;
      sigShift_q <= '0;
      bsrShift_q <= '0;
    end else if (clkEn && tckRise) begin
      if (state_q == CAP_DR) begin
        bypass_q <= 1'b0;
        idShift_q <= identity;
        sigShift_q <= USER_SIG_VALUE;
        if (path == PATH_BSR) begin
          bsrShift_q <= capVal;
        end
      end else if (state_q == SH_DR) begin
        bypass_q <= tdiSync_q[1];
        idShift_q <= {tdiSync_q[1], idShift_q[ID_WIDTH-1:1]};
        sigShift_q <= {tdiSync_q[1], sigShift_q[USER_SIG_WIDTH-1:1]};
        if (path == PATH_BSR) begin
          bsrShift_q <= {tdiSync_q[1], bsrShift_q[BSR_LEN-1:1]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bsrHold_q <= '0;
    end else if (clkEn && tckRise && state_q == UPD_DR && path == PATH_BSR) begin
      bsrHold_q <= bsrShift_q;
    end
  end

  always_comb begin
    case (state_q)
      SH_IR: serialBit = irShift_q[0];
      SH_DR: begin
        case (path)
          PATH_IDENT: serialBit = idShift_q[0];
          PATH_USERSIG: serialBit = sigShift_q[0];
          PATH_BSR: serialBit = bsrShift_q[0];
          PATH_USER_A: serialBit = utdoSync_q[1];
          PATH_USER_B: serialBit = utdoSync_q[1];
          default: serialBit = bypass_q;
        endcase
      end
      default: serialBit = 1'b0;
    endcase
  end

  assign tdoDrive = (state_q == SH_IR) || (state_q == SH_DR);

  // Output bit queued on falling edge, drained into the pin flop
  bst_skid u_skid (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .inValid(tckFall && tdoDrive),
    .inReady(bufInReady),
    .inData(serialBit),
    .outValid(bufValid),
    .outReady(downReady),
    .outData(bufData)
  );

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      testDataOut <= 1'b0;
      testDataOutEn <= 1'b0;
    end else if (clkEn) begin
      if (bufValid && downReady) begin
        testDataOut <= bufData;
      end
      if (tckFall) begin
        testDataOutEn <= tdoDrive && bufInReady;
      end
    end
  end

  // Pin control per instruction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= '0;
      pinOutEn <= '0;
      pullKeepOut <= 1'b0;
      activeInstr <= IR_RESET_VAL;
    end else if (clkEn) begin
      activeInstr <= ir_q;
      pullKeepOut <= pullKeepIn;
      case (ir_q)
        OP_EXTEST, OP_CLAMP: begin
          pinOut <= bsrHold_q;
          pinOutEn <= '1;
        end
        OP_FLOAT: begin
          pinOut <= '0;
          pinOutEn <= '0;
        end
        default: begin
          pinOut <= coreOut;
          pinOutEn <= coreOutEn;
        end
      endcase
    end
  end

  // User chain exposure
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      userSelA <= 1'b0;
      userSelB <= 1'b0;
      userTapState <= 4'h0;
      userTdi <= 1'b0;
      userCapture <= 1'b0;
      userShift <= 1'b0;
      userUpdate <= 1'b0;
    end else if (clkEn) begin
      userSelA <= (path == PATH_USER_A);
      userSelB <= (path == PATH_USER_B);
      userTapState <= state_q;
      userTdi <= tdiSync_q[1];
      userCapture <= tckRise && state_q == CAP_DR;
      userShift <= tckRise && state_q == SH_DR;
      userUpdate <= tckRise && state_q == UPD_DR;
    end
  end
endmodule

// ==== tb/bst_host.sv ====
// Model of the external scan host on the test link
module bst_host (
  output logic testClk, // Test clock
  output logic modeSel, // Mode select
  output logic testDataIn, // Data to device
  input wire logic testDataOut // Data from device
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    testClk = 1'b0;
    modeSel = 1'b1;
    testDataIn = 1'b0;
  end
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    modeSel = tms;
    testDataIn = tdi;
    #32 testClk = 1'b1;
    tdo = testDataOut;
    #32 testClk = 1'b0;
  endtask
  task automatic reset_link;
    logic t;
    repeat (5) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
  endtask
  // Idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [255:0] din,
                      output logic [255:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, 1'b0, t);
    if (ir) tick(1'b1, 1'b0, t);
    tick(1'b0, 1'b0, t);
    tick(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, ~din[n-1], t);
    tick(1'b0, din[n-1], t);
  endtask
endmodule

// ==== tb/bst_tap_unit_props.sv ====
// Checker of port relations for the instruction unit
module bst_tap_props import bst_pkg::*; #(
  parameter int BSR_LEN = BSR_SMALL // Boundary length
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic clkEn, // Clock enable
  input wire logic testDataOutEn, // Data out enable
  input wire logic [BSR_LEN-1:0] coreOut, // Core levels
  input wire logic [BSR_LEN-1:0] coreOutEn, // Core enables
  input wire logic pullKeepIn, // Configured keepers
  input wire logic [BSR_LEN-1:0] pinOut, // Pin levels
  input wire logic [BSR_LEN-1:0] pinOutEn, // Pin enables
  input wire logic pullKeepOut, // Keeper enable
  input wire logic [9:0] activeInstr, // Instruction
  input wire logic userSelA, // Chain A
  input wire logic userSelB, // Chain B
  input wire logic [3:0] userTapState, // Controller state
  input wire logic userShift // Shift pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_float; (activeInstr == OP_FLOAT) [*2] |-> pinOutEn == '0; endproperty
  a_float: assert property (p_float) else $error("pins driven while floating");
  property p_clamp; (activeInstr == OP_CLAMP) [*2] |-> &pinOutEn; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp left a pin undriven");
  property p_extest; (activeInstr == OP_EXTEST) [*2] |-> &pinOutEn; endproperty
  a_extest: assert property (p_extest) else $error("extest left a pin undriven");
  property p_sample;
    (activeInstr == OP_SAMPLE) [*2] |-> pinOut == $past(coreOut) && pinOutEn == $past(coreOutEn);
  endproperty
  a_sample: assert property (p_sample) else $error("sample disturbed pins");
  property p_bypass; (activeInstr == OP_BYPASS) [*2] |-> pinOut == $past(coreOut); endproperty
  a_bypass: assert property (p_bypass) else $error("bypass disturbed pins");
  property p_keep; clkEn |=> pullKeepOut == $past(pullKeepIn); endproperty
  a_keep: assert property (p_keep) else $error("keeper setting altered");
  property p_selA; (activeInstr == OP_USER_A) [*2] |-> userSelA && !userSelB; endproperty
  a_selA: assert property (p_selA) else $error("first chain not selected");
  property p_selB; (activeInstr == OP_USER_B) [*2] |-> userSelB && !userSelA; endproperty
  a_selB: assert property (p_selB) else $error("second chain not selected");
  property p_excl; !(userSelA && userSelB); endproperty
  a_excl: assert property (p_excl) else $error("both chains selected");
  property p_shift; userShift |=> !userShift; endproperty
  a_shift: assert property (p_shift) else $error("shift pulse too long");
  property p_instr;
    $changed(activeInstr) |-> userTapState inside {UPD_IR, RUN_IDLE, SEL_DR, TL_RESET};
  endproperty
  a_instr: assert property (p_instr) else $error("instruction changed mid scan");
  property p_tdoen;
    testDataOutEn |-> userTapState inside {SH_IR, EX1_IR, PA_IR, SH_DR, EX1_DR, PA_DR};
  endproperty
  a_tdoen: assert property (p_tdoen) else $error("data out enabled outside shift");
  c_float: cover property (activeInstr == OP_FLOAT);
  c_userA: cover property (userSelA);
  c_shift: cover property (userShift);
endmodule
bind bst_tap_unit bst_tap_props #(.BSR_LEN(BSR_LEN)) i_props (.sys_clk, .reset_n, .clkEn,
  .testDataOutEn, .coreOut,
  .coreOutEn, .pullKeepIn, .pinOut, .pinOutEn, .pullKeepOut, .activeInstr, .userSelA,
  .userSelB, .userTapState, .userShift);

// ==== tb/bst_tap_unit_tb.sv ====
// Self-checking bench for the instruction unit
module bst_tap_unit_tb import bst_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BSR_LEN = BSR_SMALL;
  localparam int NB = BSR_LEN / 8;
  logic sysClk, resetN, clkEn, testClk, modeSel, testDataIn, testDataOut, testDataOutEn;
  logic [BSR_LEN-1:0] pinIn, coreOut, coreOutEn, pinOut, pinOutEn;
  logic pullKeepIn, pullKeepOut, userSelA, userSelB, userTdi, userCapture, userShift;
  logic userUpdate, userTdo, downReady, stallOn;
  logic [9:0] activeInstr;
  logic [3:0] userTapState;
  logic [255:0] d;
  int n_mismatch, comparisons, cycles;
  int nCapture, nShift, nUpdate, nOutEn;
  logic [7:0] userBits;
  bst_tap_unit #(.BSR_LEN(BSR_LEN)) i_dut (.sys_clk(sysClk), .reset_n(resetN), .clkEn,
    .testClk, .modeSel, .testDataIn, .testDataOut, .testDataOutEn, .pinIn, .coreOut,
    .coreOutEn, .pullKeepIn, .pinOut, .pinOutEn, .pullKeepOut, .activeInstr, .userSelA,
    .userSelB, .userTapState, .userTdi, .userCapture, .userShift, .userUpdate, .userTdo,
    .downReady);
  bst_host i_host (.testClk, .modeSel, .testDataIn, .testDataOut);
  initial begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  // Sink stalls one cycle in eight when asked; tallies of user-side pulses
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    downReady <= !(stallOn && cycles[2:0] == 3'h0);
    if (userCapture) begin
      nCapture <= nCapture + 1;
    end
    if (userShift) begin
      nShift <= nShift + 1;
      userBits <= {userTdi, userBits[7:1]};
    end
    if (userUpdate) begin
      nUpdate <= nUpdate + 1;
    end
    if (testDataOutEn) begin
      nOutEn <= nOutEn + 1;
    end
  end
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [255:0] exp, input logic [255:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic load(input logic [9:0] op);
    i_host.scan(1'b1, 10, {246'h0, op}, d);
    check("ir capture", IR_CAPTURE_VAL, d);
    check("instruction", op, activeInstr);
  endtask
  task automatic t_ident;
    int n0;
    check("reset instruction", OP_IDENT, activeInstr);
    n0 = nOutEn;
    i_host.scan(1'b0, 32, '0, d);
    check("identity", {ID_VERSION, ID_PART, ID_MAKER, 1'b1}, d);
    // Enable spans 32 link periods of 64 ns, sync quantisation aside
    check("tdo enable window", 1'b1, (nOutEn - n0) inside {[408:411]});
  endtask
  task automatic t_usersig;
    load(OP_USERSIG);
    i_host.scan(1'b0, 32, '0, d);
    check("user signature", 32'hFFFFFFFF, d);
  endtask
  task automatic t_sample;
    @(posedge sysClk);
    pinIn <= {NB{8'h5A}};
    load(OP_SAMPLE);
    check("sample pins", coreOut, pinOut);
    i_host.scan(1'b0, BSR_LEN + 8, {32{8'hC3}}, d);
    check("sampled", {8'hC3, {NB{8'h5A}}}, d);
  endtask
  task automatic t_extest;
    @(posedge sysClk);
    pinIn <= {NB{8'h96}};
    load(OP_EXTEST);
    check("extest levels", {NB{8'hC3}}, pinOut);
    i_host.scan(1'b0, BSR_LEN, {32{8'hC3}}, d);
    check("extest capture", {NB{8'h96}}, d);
  endtask
  task automatic t_bypass;
    logic [9:0] ops [3] = '{OP_BYPASS, OP_FLOAT, OP_CLAMP};
    for (int k = 0; k < 3; k++) begin
      load(ops[k]);
      if (k == 1) check("float enables", '0, pinOutEn);
      if (k == 1) check("keepers", 1'b1, pullKeepOut);
      if (k == 2) check("clamp levels", {NB{8'hC3}}, pinOut);
      i_host.scan(1'b0, 8, 8'hA5, d);
      check("bypass delay", 8'h4A, d);
    end
  endtask
  task automatic t_user;
    int n0;
    int n1;
    int n2;
    for (int k = 0; k < 2; k++) begin
      @(posedge sysClk);
      userTdo <= (k == 0);
      stallOn <= 1'b1;
      load(k == 0 ? OP_USER_A : OP_USER_B);
      check("chain select", {k == 0, k == 1}, {userSelA, userSelB});
      check("controller state", RUN_IDLE, userTapState);
      n0 = nCapture;
      n1 = nShift;
      n2 = nUpdate;
      i_host.scan(1'b0, 8, 8'h3C, d);
      check("user chain data", k == 0 ? 8'hFF : 8'h00, d);
      check("capture pulses", 1, nCapture - n0);
      check("shift pulses", 8, nShift - n1);
      check("update pulses", 1, nUpdate - n2);
      check("user chain input", 8'h3C, userBits);
    end
  endtask
  task automatic t_freeze;
    @(posedge sysClk);
    clkEn <= 1'b0;
    pullKeepIn <= 1'b0;
    repeat (8) @(negedge sysClk);
    check("frozen keepers", 1'b1, pullKeepOut);
    check("frozen instruction", OP_USER_B, activeInstr);
    @(posedge sysClk);
    clkEn <= 1'b1;
    repeat (2) @(negedge sysClk);
    check("keepers follow", 1'b0, pullKeepOut);
    @(posedge sysClk);
    pullKeepIn <= 1'b1;
  endtask
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    resetN = 1'b0;
    clkEn = 1'b1;
    pinIn = '0;
    coreOut = {NB{8'h3C}};
    coreOutEn = {NB{8'hF0}};
    pullKeepIn = 1'b1;
    userTdo = 1'b0;
    stallOn = 1'b0;
    repeat (4) @(posedge sysClk);
    resetN <= 1'b1;
    repeat (4) @(posedge sysClk);
    fork
      begin
        i_host.reset_link;
        t_ident;
        t_usersig;
        t_sample;
        t_extest;
        t_bypass;
        t_user;
        t_freeze;
      end
      begin
        wait (cycles == 40000);
        n_mismatch++;
        $display("wrong value run time expected done seen timeout");
      end
    join_any
    print_verdict;
  end
endmodule
